// >>> pwr_path_defs.svh
// Register offsets, field positions, reset values and timing counts for the power path block
`ifndef PWR_PATH_DEFS_SVH
`define PWR_PATH_DEFS_SVH

// Register byte offsets
`define REG_PORT0_CTRL      8'h00
`define REG_PORT1_CTRL      8'h04
`define REG_PORT0_STATUS    8'h08
`define REG_PORT1_STATUS    8'h0C
`define REG_GLOBAL          8'h10

// Control register fields
`define CTRL_SRC_EN         0
`define CTRL_VCONN_EN       1
`define CTRL_FRS_EN         2
`define CTRL_SINK_OVP_EN    3
`define CTRL_SYS_GATE_EN    4
`define CTRL_BUS_GATE_EN    5
`define CTRL_RP_LO          6
`define CTRL_RP_HI          7
`define CTRL_VMAX_LO        8
`define CTRL_VMAX_HI        15
`define CTRL_RESET          16'h0000

// Global register fields
`define GLB_BOOT            0
`define GLB_VCONN_CLR0      1
`define GLB_VCONN_CLR1      2
`define GLB_SAFE            3

// Rp advertisement codes
`define RP_DEFAULT          2'h0

// Timing
`define CLK_PERIOD_NS       10
`define CC_DEBOUNCE_NS      10000
`define CC_DEBOUNCE_CYC     (`CC_DEBOUNCE_NS / `CLK_PERIOD_NS)
`define ERR_RECOVERY_NS     25000000
`define ERR_RECOVERY_CYC    (`ERR_RECOVERY_NS / `CLK_PERIOD_NS)

`endif

// >>> pwr_path_pkg.sv
// Types shared by the power path block and its users
package pwr_path_pkg;

    // Per-port comparator outputs, all active high
    typedef struct packed {
        logic bus_ovp;       // Bus above overvoltage_limit
        logic bus_ovp_clr;   // Bus below overvoltage_limit minus hysteresis
        logic bus_ovp_sys;   // Bus above scaled system threshold
        logic src_rcp;       // Bus above supply rail by reverse threshold
        logic frs_trip;      // Bus below supply rail minus reverse threshold
        logic vconn_oc;      // VCONN current above limit
        logic otsd;          // Local overtemperature
        logic sink_rcp;      // System rail above bus by reverse threshold
        logic bus_uvlo;      // Bus below bus undervoltage threshold
        logic cc1_rd;        // config_pin_one sees Rd
        logic cc1_ra;        // config_pin_one sees Ra
        logic cc2_rd;        // config_pin_two sees Rd
        logic cc2_ra;        // config_pin_two sees Ra
    } cmp_t;

    typedef enum logic [2:0] {
        ST_UNATT = 3'b000,
        ST_CABLE = 3'b001,
        ST_SINK  = 3'b010,
        ST_ACC   = 3'b011,
        ST_ERR   = 3'b100
    } att_state_t;

    typedef struct packed {
        att_state_t  st;
        logic        flip;        // Sink (or lone Ra) on config_pin_two
        logic        cable;       // Ra seen on the pin opposite the sink
        logic [9:0]  det_cnt;
        logic [21:0] err_cnt;
        logic        src_closed;  // Source switch has closed since attach
        logic        vconn_latch;
        logic        ovp_hold;
        logic [15:0] ctrl;
        cmp_t        sync1;
        cmp_t        sync2;
        logic        bus_src;
        logic        vconn;
        logic        vconn_clamp;
        logic        sys_gate;
        logic        bus_gate;
        logic        discharge;
        logic [1:0]  rp_sel;
        logic [1:0]  cc_mon;
        logic [8:0]  ovp_limit;
    } port_state_t;

    typedef struct packed {
        port_state_t [1:0] port;
        logic              uvlo1;
        logic              uvlo2;
        logic              boot;
        logic              safe;
        logic              straps_taken;
        logic [15:0]       rdata;
    } state_t;

endpackage

// >>> pwr_path.sv
// Dual-port Type-C power path protection and source attach control
//
// Functional notes
// [R1] Overvoltage limit follows the contract's maximum bus voltage automatically.
// [R2] Bus overvoltage while sourcing opens source switch and enters ErrorRecovery.
// [R3] Supply undervoltage while sourcing opens source switch and enters ErrorRecovery.
// [R4] Reverse current opens source switch; it recloses once condition clears.
// [R5] Enabled fast role swap closes source switch when bus sags below supply.
// [R6] VCONN overcurrent clamps switch as current source; no reverse blocking.
// [R7] Overtemperature latches VCONN off and sends port to ErrorRecovery on the same edge.
// [R8] Supply undervoltage turns off both ports' VCONN switches unconditionally.
// [R9] Enabled sink overvoltage opens system sink gate above scaled threshold.
// [R10] Bus overvoltage opens bus sink gate; recloses below limit minus hysteresis.
// [R11] Both sink gates may be on; bus gate alone limits bus voltage.
// [R12] Dead-battery boot: both gates follow overvoltage, unless safe strap set.
// [R13] System rail above bus by reverse threshold opens bus sink gate.
// [R14] Bus undervoltage opens bus sink gate until it clears.
// [R15] Bus discharge pull-down is applied whenever port is unattached.
// [R16] Both pins open: watch both, no bus power, no VCONN.
// [R17] Rd and open: bus power, no VCONN, watch Rd pin only.
// [R18] Ra and open: no power, watch open pin attach, Ra pin detach.
// [R19] Ra and Rd: bus power, VCONN on Ra pin, watch Rd pin.
// [R20] Debug or audio accessory: either pin may signal detach.
// [R21] Default Rp until source switch closes; firmware may then raise it.
// [R22] Detach registers after monitored pin stays open for debounce time.
// [R23] Every comparator output passes a two-stage synchroniser before use.
`timescale 1ns/1ps
`include "pwr_path_defs.svh"

module pwr_path #(
    parameter int ERR_CYC = `ERR_RECOVERY_CYC
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    // Register port
    input  wire logic [7:0]             i_addr,
    input  wire logic [15:0]            i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    output logic      [15:0]            o_rdata,
    // Analog comparators and straps
    input  pwr_path_pkg::cmp_t [1:0]    i_cmp,
    input  wire logic                   i_supply_uvlo,
    input  wire logic                   i_dead_battery,
    input  wire logic                   i_safe_strap,
    // Switch and gate controls per port
    output logic      [1:0]             o_bus_source_switch,
    output logic      [1:0]             o_vconn_source_switch,
    output logic      [1:0]             o_vconn_on_pin_two,
    output logic      [1:0]             o_vconn_clamp,
    output logic      [1:0]             o_system_sink_gate,
    output logic      [1:0]             o_bus_sink_gate,
    output logic      [1:0]             o_bus_discharge,
    output logic      [3:0]             o_rp_sel,
    output logic      [3:0]             o_cc_monitor,
    output logic      [17:0]            o_overvoltage_limit
);
    import pwr_path_pkg::*;

    localparam logic [9:0]  DET_CYC = 10'(`CC_DEBOUNCE_CYC);
    localparam logic [21:0] ERR_N   = 22'(ERR_CYC);

    state_t s_q;
    state_t s_d;

    // Next state: synchronisers, attach machines, switch control, register port
    always_comb begin
        port_state_t p;
        cmp_t        c;
        logic        cc1_open;
        logic        cc2_open;
        logic        mon_open;
        logic        fault;
        logic        ovp_trip;
        logic [15:0] sts;
        p        = '0;
        c        = '0;
        cc1_open = 1'b0;
        cc2_open = 1'b0;
        mon_open = 1'b0;
        fault    = 1'b0;
        ovp_trip = 1'b0;
        sts      = '0;
        s_d      = s_q;
        s_d.rdata = 16'h0000;

        // Supply undervoltage synchroniser
        s_d.uvlo1 = i_supply_uvlo;                                  // [R23]
        s_d.uvlo2 = s_q.uvlo1;                                      // [R23]

        // Straps are caught once, on the first edge after reset release
        if (!s_q.straps_taken) begin
            s_d.straps_taken = 1'b1;
            s_d.boot         = i_dead_battery;
            s_d.safe         = i_safe_strap;
        end

        for (int i = 0; i < 2; i++) begin
            p = s_q.port[i];
            p.sync1 = i_cmp[i];                                     // [R23]
            p.sync2 = s_q.port[i].sync1;                            // [R23]
            c = s_q.port[i].sync2;
            cc1_open = !c.cc1_rd && !c.cc1_ra;
            cc2_open = !c.cc2_rd && !c.cc2_ra;

            // Limit tracks the contract maximum plus one eighth margin
            p.ovp_limit = {1'b0, p.ctrl[`CTRL_VMAX_HI:`CTRL_VMAX_LO]}
                        + {4'h0, p.ctrl[`CTRL_VMAX_HI:`CTRL_VMAX_LO+3]}; // [R1]

            // Faults that send the port to ErrorRecovery
            fault = (s_q.port[i].bus_src && (c.bus_ovp || s_q.uvlo2)) // [R2] [R3]
                  || c.otsd;                                        // [R7]
            if (c.otsd) begin
                p.vconn_latch = 1'b1;                               // [R7]
            end

            // Detach timing on the monitored pin
            unique case (s_q.port[i].st)
                ST_SINK:  mon_open = s_q.port[i].flip ? cc2_open : cc1_open; // [R17] [R19]
                ST_CABLE: mon_open = s_q.port[i].flip ? cc2_open : cc1_open; // [R18]
                ST_ACC:   mon_open = cc1_open || cc2_open;          // [R20]
                default:  mon_open = 1'b0;
            endcase
            p.det_cnt = mon_open ? s_q.port[i].det_cnt + 10'h001 : 10'h000; // [R22]

            unique case (s_q.port[i].st)
                ST_UNATT: begin
                    p.src_closed = 1'b0;
                    // Both pins watched; no power until something is seen
                    if ((c.cc1_rd && c.cc2_rd) || (c.cc1_ra && c.cc2_ra)) begin // [R16]
                        p.st = ST_ACC;                              // [R20]
                    end else if (c.cc1_rd || c.cc2_rd) begin
                        p.st    = ST_SINK;                          // [R17] [R19]
                        p.flip  = c.cc2_rd;
                        p.cable = c.cc1_ra || c.cc2_ra;
                    end else if (c.cc1_ra || c.cc2_ra) begin
                        p.st    = ST_CABLE;                         // [R18]
                        p.flip  = c.cc2_ra;
                        p.cable = 1'b1;
                    end
                end
                ST_CABLE: begin
                    // Sink appearing on the open pin completes the attach
                    if (s_q.port[i].flip ? c.cc1_rd : c.cc2_rd) begin // [R18]
                        p.st   = ST_SINK;
                        p.flip = !s_q.port[i].flip;
                    end else if (p.det_cnt >= DET_CYC) begin
                        p.st = ST_UNATT;                            // [R22]
                    end
                end
                ST_SINK, ST_ACC: begin
                    if (p.det_cnt >= DET_CYC) begin
                        p.st = ST_UNATT;                            // [R22]
                    end
                end
                ST_ERR: begin
                    p.err_cnt = s_q.port[i].err_cnt + 22'h00_0001;
                    if (s_q.port[i].err_cnt >= ERR_N - 22'h00_0001) begin
                        p.st = ST_UNATT;
                    end
                end
                default: p.st = ST_ERR;
            endcase
            if (fault && s_q.port[i].st != ST_ERR) begin
                p.st      = ST_ERR;                                 // [R2] [R3] [R7]
                p.err_cnt = '0;
            end
            if (p.st != s_q.port[i].st) begin
                p.det_cnt = '0;
            end

            // Source switch: attached sink or fast role swap, blocked by reverse current
            p.bus_src = !fault && s_q.port[i].st != ST_ERR && !c.src_rcp // [R4]
                      && ((s_q.port[i].st == ST_SINK
                           && s_q.port[i].ctrl[`CTRL_SRC_EN])       // [R17] [R19]
                          || (s_q.port[i].ctrl[`CTRL_FRS_EN] && c.frs_trip)); // [R5]
            if (s_q.port[i].bus_src) begin
                p.src_closed = 1'b1;                                // [R21]
            end
            p.rp_sel = s_q.port[i].src_closed
                     ? s_q.port[i].ctrl[`CTRL_RP_HI:`CTRL_RP_LO] : `RP_DEFAULT; // [R21]

            // VCONN only toward a cable Ra while a sink is present
            p.vconn = s_q.port[i].st == ST_SINK && s_q.port[i].cable // [R19]
                    && s_q.port[i].ctrl[`CTRL_VCONN_EN]
                    && !p.vconn_latch && !c.otsd                    // [R7]
                    && !s_q.uvlo2;                                  // [R8]
            // Clamp is an analog mode; the switch keeps conducting both ways
            p.vconn_clamp = s_q.port[i].vconn && c.vconn_oc;        // [R6]

            // Sink side: overvoltage hold with hysteresis
            if (c.bus_ovp) begin
                p.ovp_hold = 1'b1;                                  // [R10]
            end else if (c.bus_ovp_clr) begin
                p.ovp_hold = 1'b0;                                  // [R10]
            end
            ovp_trip = p.ovp_hold || c.bus_ovp;
            if (s_q.boot) begin
                // Firmware is not running; hardware owns both gates
                p.sys_gate = !ovp_trip && !s_q.safe;                // [R12]
                p.bus_gate = !ovp_trip && !s_q.safe;                // [R12]
            end else begin
                p.sys_gate = s_q.port[i].ctrl[`CTRL_SYS_GATE_EN]
                           && !(s_q.port[i].ctrl[`CTRL_SINK_OVP_EN] && c.bus_ovp_sys); // [R9]
                // Bus gate alone holds the bus under the limit [R11]
                p.bus_gate = s_q.port[i].ctrl[`CTRL_BUS_GATE_EN] && !ovp_trip // [R10]
                           && !c.sink_rcp                           // [R13]
                           && !c.bus_uvlo;                          // [R14]
            end

            p.discharge = p.st == ST_UNATT;                         // [R15]
            unique case (p.st)
                ST_UNATT, ST_ACC: p.cc_mon = 2'b11;                 // [R16] [R20]
                ST_SINK:  p.cc_mon = p.flip ? 2'b10 : 2'b01;        // [R17] [R19]
                ST_CABLE: p.cc_mon = 2'b11;                         // [R18]
                default:  p.cc_mon = 2'b00;
            endcase
            s_d.port[i] = p;
        end

        // VCONN latch release; an overtemperature in the same cycle keeps it set
        if (i_wr && i_addr == `REG_GLOBAL) begin
            if (i_wdata[`GLB_VCONN_CLR0] && !s_q.port[0].sync2.otsd) begin
                s_d.port[0].vconn_latch = 1'b0;
            end
            if (i_wdata[`GLB_VCONN_CLR1] && !s_q.port[1].sync2.otsd) begin
                s_d.port[1].vconn_latch = 1'b0;
            end
            if (!i_wdata[`GLB_BOOT]) begin
                s_d.boot = 1'b0;
            end
        end
        if (i_wr && i_addr == `REG_PORT0_CTRL) begin
            s_d.port[0].ctrl = i_wdata;
        end
        if (i_wr && i_addr == `REG_PORT1_CTRL) begin
            s_d.port[1].ctrl = i_wdata;
        end

        // Read data stands one cycle after the strobe; unmapped reads return zero
        if (i_rd) begin
            if (i_addr == `REG_PORT0_STATUS || i_addr == `REG_PORT1_STATUS) begin
                p = s_q.port[i_addr == `REG_PORT1_STATUS];
                sts = {4'h0, p.st == ST_ERR, p.ovp_hold, p.discharge, p.bus_gate,
                       p.sys_gate, p.vconn_latch, p.vconn, p.bus_src, p.flip, p.st};
            end
            unique case (i_addr)
                `REG_PORT0_CTRL:   s_d.rdata = s_q.port[0].ctrl;
                `REG_PORT1_CTRL:   s_d.rdata = s_q.port[1].ctrl;
                `REG_PORT0_STATUS: s_d.rdata = sts;
                `REG_PORT1_STATUS: s_d.rdata = sts;
                `REG_GLOBAL:       s_d.rdata = {12'h000, s_q.safe, 2'b00, s_q.boot};
                default:           s_d.rdata = 16'h0000;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flip-flops
    always_comb begin
        o_rdata = s_q.rdata;
        for (int i = 0; i < 2; i++) begin
            o_bus_source_switch[i]           = s_q.port[i].bus_src;
            o_vconn_source_switch[i]         = s_q.port[i].vconn;
            o_vconn_on_pin_two[i]            = !s_q.port[i].flip;
            o_vconn_clamp[i]                 = s_q.port[i].vconn_clamp;
            o_system_sink_gate[i]            = s_q.port[i].sys_gate;
            o_bus_sink_gate[i]               = s_q.port[i].bus_gate;
            o_bus_discharge[i]               = s_q.port[i].discharge;
            o_rp_sel[2*i +: 2]               = s_q.port[i].rp_sel;
            o_cc_monitor[2*i +: 2]           = s_q.port[i].cc_mon;
            o_overvoltage_limit[9*i +: 9]    = s_q.port[i].ovp_limit;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_ovp_src_off: assert property (s_q.port[0].bus_src && i_cmp[0].bus_ovp
        |-> ##[1:3] !o_bus_source_switch[0]) else $error("source stays on in overvoltage"); // [R2]
    a_uvlo_err: assert property (o_bus_source_switch[0] && i_supply_uvlo && s_q.uvlo2
        |=> s_q.port[0].st == ST_ERR) else $error("uvlo did not enter recovery"); // [R3]
    a_rcp_src_off: assert property (i_cmp[0].src_rcp [*3] |=> !o_bus_source_switch[0])
        else $error("source on during reverse current"); // [R4]
    a_frs_fast_on: assert property (s_q.port[0].ctrl[`CTRL_FRS_EN] && i_cmp[0].frs_trip
        && !i_cmp[0].src_rcp && !i_cmp[0].otsd && !i_supply_uvlo && !i_cmp[0].bus_ovp
        && s_q.port[0].st != ST_ERR ##1 $stable(s_q.port[0].ctrl) [*2] ##1 1'b1
        |-> o_bus_source_switch[0] || s_q.port[0].st == ST_ERR)
        else $error("fast role swap did not close switch"); // [R5]
    a_otsd_latch: assert property (i_cmp[0].otsd |-> ##[1:3] (s_q.port[0].vconn_latch
        && !o_vconn_source_switch[0])) else $error("overtemperature did not latch"); // [R7]
    a_uvlo_vconn: assert property (i_supply_uvlo [*3] |=> o_vconn_source_switch == 2'b00)
        else $error("vconn on during supply undervoltage"); // [R8]
    a_ovp_bus_gate: assert property (i_cmp[1].bus_ovp [*3] |=> !o_bus_sink_gate[1])
        else $error("bus sink gate on in overvoltage"); // [R10]
    a_discharge: assert property (o_bus_discharge[0] |-> s_q.port[0].st == ST_UNATT
        && !o_bus_source_switch[0]) else $error("discharge outside unattached"); // [R15]
    a_rp_default: assert property (!s_q.port[0].src_closed |=> o_rp_sel[1:0] == 2'b00)
        else $error("Rp raised before switch closed"); // [R21]
    // Switch output lags the state by one edge, so both facts are taken one edge back
    a_vconn_needs_ra: assert property (o_vconn_source_switch[1]
        |-> $past(s_q.port[1].cable) && $past(s_q.port[1].st) == ST_SINK)
        else $error("vconn without cable"); // [R19]

    c_sink_attach: cover property (s_q.port[0].st == ST_UNATT ##1 s_q.port[0].st == ST_SINK);
    c_err_exit: cover property (s_q.port[0].st == ST_ERR ##1 s_q.port[0].st == ST_UNATT);
    c_vconn_on: cover property (o_vconn_source_switch[0] && o_bus_source_switch[0]);
    c_detach: cover property (s_q.port[1].st == ST_SINK ##1 s_q.port[1].st == ST_UNATT);

endmodule

// >>> cc_partner.sv
// Port partner model: turns pin terminations and bus conditions into comparator levels
`timescale 1ns/1ps

module cc_partner (
    // Termination seen on each config pin: 0 open, 1 Rd, 2 Ra
    input  wire logic [1:0]          i_pin_one,
    input  wire logic [1:0]          i_pin_two,
    // Bus and rail conditions, cmp_t order from bus_ovp down to bus_uvlo
    input  wire logic [8:0]          i_bus_cond,
    // Comparator levels toward the block
    output pwr_path_pkg::cmp_t       o_cmp
);
    import pwr_path_pkg::*;

    // Hysteresis is modelled as the plain inverse of overvoltage, the harshest legal case
    always_comb begin
        o_cmp             = cmp_t'({i_bus_cond, 4'h0});
        o_cmp.bus_ovp_clr = !i_bus_cond[8];
        o_cmp.cc1_rd      = (i_pin_one == 2'h1);
        o_cmp.cc1_ra      = (i_pin_one == 2'h2);
        o_cmp.cc2_rd      = (i_pin_two == 2'h1);
        o_cmp.cc2_ra      = (i_pin_two == 2'h2);
    end
endmodule

// >>> test_type_c_power_path_protection_attach.sv
// Self-checking bench for the power path block with one partner per port
`timescale 1ns/1ps

module test_type_c_power_path_protection_attach;
    import pwr_path_pkg::*;
    logic              i_clk = 0, i_nrst = 0, i_wr = 0, i_rd = 0, i_supply_uvlo = 0, db = 0;
    logic [7:0]        i_addr = 0;
    logic [15:0]       i_wdata = 0, o_rdata, v;
    logic [1:0]        p1 [2] = '{2'h0, 2'h0};
    logic [1:0]        p2 [2] = '{2'h0, 2'h0};
    logic [8:0]        cnd [2] = '{9'h000, 9'h000};
    cmp_t [1:0]        i_cmp;
    logic [1:0]        src, vcn, vp2, clamp, sys, bus, dis;
    logic [3:0]        rp, mon;
    logic [17:0]       ovl;
    int                n_mismatch = 0, n_tests = 0;

    // Short ErrorRecovery keeps the run brief
    pwr_path #(.ERR_CYC(20)) uut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp(i_cmp),
        .i_supply_uvlo(i_supply_uvlo), .i_dead_battery(db), .i_safe_strap(1'b0),
        .o_bus_source_switch(src), .o_vconn_source_switch(vcn), .o_vconn_on_pin_two(vp2),
        .o_vconn_clamp(clamp), .o_system_sink_gate(sys), .o_bus_sink_gate(bus),
        .o_bus_discharge(dis), .o_rp_sel(rp), .o_cc_monitor(mon), .o_overvoltage_limit(ovl));
    cc_partner pa (.i_pin_one(p1[0]), .i_pin_two(p2[0]), .i_bus_cond(cnd[0]), .o_cmp(i_cmp[0]));
    cc_partner pb (.i_pin_one(p1[1]), .i_pin_two(p2[1]), .i_bus_cond(cnd[1]), .o_cmp(i_cmp[1]));

    // Clock
    always #5 i_clk = ~i_clk;

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Let a few edges pass; #1 keeps checks clear of the edge itself
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1;
        v = o_rdata;
    endtask
    task automatic await_dis(input int p);
        int k;
        for (k = 0; k < 300 && dis[p] !== 1'b1; k++) tick(1);
        if (k == 300) begin
            n_mismatch++;
            $display("[ERR] discharge expected 1 seen %b", dis[p]);
            end_of_test();
        end
    endtask

    // Main sequence
    initial begin
        tick(2);
        chk("src in reset", 18'h0, src);
        i_nrst <= 1'b1;
        tick(3);
        chk("discharge idle", 18'h3, dis);
        chk("monitor idle", 18'hF, mon);
        chk("src idle", 18'h0, src);
        wr(8'h00, 16'h40BB);
        wr(8'h04, 16'h2003);
        rd(8'h00);
        chk("ctrl0", 18'h40BB, v);
        rd(8'h14);
        chk("unmapped", 18'h0, v);
        tick(3);
        chk("ovp limit", {9'h024, 9'h048}, ovl);
        chk("both sink gates", 18'h3, {sys[0], bus[0]});
        // Port 0 sink on pin one, port 1 cable on pin one and sink on pin two
        p1[0] <= 2'h1;
        p1[1] <= 2'h2;
        p2[1] <= 2'h1;
        tick(6);
        chk("src on", 18'h3, src);
        chk("vconn", 18'h2, vcn);
        chk("vconn pin", 18'h0, vp2[1]);
        chk("monitor", 18'h9, mon);
        chk("discharge off", 18'h0, dis);
        chk("rp code", 18'h2, rp);
        cnd[0] <= 9'h020;
        tick(6);
        chk("src rcp", 18'h0, src[0]);
        cnd[0] <= 9'h000;
        tick(6);
        chk("src rcp clear", 18'h1, src[0]);
        cnd[0] <= 9'h040;
        tick(6);
        chk("sys ovp", 18'h1, {sys[0], bus[0]});
        cnd[0] <= 9'h002;
        tick(6);
        chk("bus rcp", 18'h0, bus[0]);
        cnd[0] <= 9'h001;
        tick(6);
        chk("bus uvlo", 18'h0, bus[0]);
        cnd[0] <= 9'h000;
        cnd[1] <= 9'h008;
        tick(6);
        chk("bus gate back", 18'h1, bus[0]);
        chk("vconn clamp", 18'h3, {clamp[1], vcn[1]});
        cnd[1] <= 9'h000;
        i_supply_uvlo <= 1'b1;
        tick(6);
        chk("uvlo vconn", 18'h0, vcn);
        chk("uvlo src", 18'h0, src);
        rd(8'h0C);
        chk("uvlo state", 18'h4, v[2:0]);
        i_supply_uvlo <= 1'b0;
        tick(40);
        chk("recovered", 18'h3, src);
        cnd[0] <= 9'h100;
        tick(6);
        chk("ovp src bus", 18'h0, {src[0], bus[0]});
        rd(8'h08);
        chk("ovp state", 18'h4, v[2:0]);
        cnd[0] <= 9'h000;
        tick(6);
        chk("bus gate clr", 18'h1, bus[0]);
        p1[1] <= 2'h0;
        p2[1] <= 2'h0;
        tick(900);
        chk("no early detach", 18'h0, dis[1]);
        await_dis(1);
        p1[1] <= 2'h2;
        tick(6);
        chk("cable only", 18'h0, {src[1], vcn[1]});
        chk("cable monitor", 18'h3, mon[3:2]);
        cnd[1] <= 9'h004;
        tick(6);
        rd(8'h0C);
        chk("otsd latch", 18'hC, {v[6], v[2:0]});
        // Second reset with the dead-battery strap set
        cnd[1] <= 9'h000;
        db <= 1'b1;
        i_nrst <= 1'b0;
        tick(2);
        i_nrst <= 1'b1;
        tick(4);
        chk("boot gates", 18'h3, {sys[0], bus[0]});
        cnd[0] <= 9'h100;
        tick(6);
        chk("boot ovp", 18'h0, {sys[0], bus[0]});
        cnd[0] <= 9'h000;
        tick(6);
        chk("boot clear", 18'h3, {sys[0], bus[0]});
        wr(8'h00, 16'h0004);
        cnd[0] <= 9'h010;
        tick(6);
        chk("frs on", 18'h1, src[0]);
        end_of_test();
    end
endmodule
